// file: rtl/plcc_ctrl.sv
// Purpose: Single-pin pulse-count control of LED sink currents.
// Assumes: 100 MHz clk; ctrl_pin and analog flags are asynchronous.
// Notes:   Timeouts are parameters so a bench can shorten them.
//          One timer measures both the high run (latch) and the low run (off).
//          Each pin phase must span more than one clock to be seen by the synchroniser.
//          Counts beyond sixteen hold at sixteen.
`include "plcc_defs.svh"

module plcc_ctrl #(
	parameter int unsigned OFF_CYCLES = `PLCC_OFF_CYCLES,  // Off timeout in clocks.
	parameter int unsigned LAT_CYCLES = `PLCC_LAT_CYCLES   // Latch timeout in clocks.
) (
	input  wire logic                   clk,          // System clock, 100 MHz.
	input  wire logic                   sys_rst,      // Asynchronous reset, active high.
	input  wire logic                   clk_en,       // Freezes all state while low.
	input  wire logic                   ctrl_pin,     // Enable and set pin.
	input  wire logic                   sink_dropout, // Any sink near dropout.
	input  wire logic                   sink_unterm,  // Unused sink not tied to pump output.
	output logic                        enabled,      // Device on.
	output plcc_pkg::plcc_setting_t     setting,      // Setting applied to the sinks.
	output logic [3:0]                  setting_idx,  // Applied setting, 0 means count 1.
	output plcc_pkg::plcc_pump_t        pump_mode     // Backlight pump mode.
);

	localparam int CW = 20;  // Width of the timeout counter.
	// The shared timer stops at the larger of the two timeouts; stopping at the
	// smaller one would freeze it short of the other and hide that event.
	localparam int unsigned TMR_TOP = (LAT_CYCLES > OFF_CYCLES) ? LAT_CYCLES : OFF_CYCLES;

	// Synchronisers; the first stage feeds only the second.
	logic [1:0] pin_sync_reg;   // Pin synchroniser.
	logic [1:0] drop_sync_reg;  // Dropout synchroniser.
	logic [1:0] unt_sync_reg;   // Termination synchroniser.
	logic       pin_d_reg;      // Previous synchronised pin level.

	// Control state.
	plcc_pkg::plcc_state_t   st_reg, st_next;      // On or off.
	logic [`PLCC_CNT_W-1:0]  cnt_reg, cnt_next;    // Edges counted since last latch.
	logic [CW-1:0]           tmr_reg, tmr_next;    // High or low time counter.
	logic [3:0]              idx_reg, idx_next;    // Applied setting index.
	plcc_pkg::plcc_setting_t set_reg, set_next;    // Applied sink setting.

	// Synchronised pin level and its rising edge.
	logic pin_s;    // Synchronised pin.
	logic rise;     // Rising edge of the pin.

	// Decode a setting index (count minus one) to sink levels.
	// The low two bits pick the level within a group of four; the high two
	// bits pick which groups are on, or the low-current range for the last four.
	function automatic plcc_pkg::plcc_setting_t decode(input logic [3:0] idx);
		plcc_pkg::plcc_setting_t s;
		plcc_pkg::plcc_level_t   lv;
		case (idx[1:0])
			2'h0:    lv = `PLCC_LVL_20MA;
			2'h1:    lv = `PLCC_LVL_14MA;
			2'h2:    lv = `PLCC_LVL_10MA;
			default: lv = `PLCC_LVL_7MA;
		endcase
		// Start with both groups off.
		s = '0;
		case (idx[3:2])
			2'h0: begin
				s.main_on = 1'b1;
				s.sub_on  = 1'b1;
			end
			2'h1: begin
				s.main_on = 1'b1;
			end
			2'h2: begin
				s.sub_on  = 1'b1;
			end
			default: begin
				// The low-current range has level codes of its own, except 2 mA, which shares code 0 with off.
				s.main_on = 1'b1;
				s.sub_on  = 1'b1;
				s.low_iq  = 1'b1;
				case (idx[1:0])
					2'h0:    lv = `PLCC_LVL_50UA;
					2'h1:    lv = `PLCC_LVL_500UA;
					2'h2:    lv = `PLCC_LVL_1MA;
					default: lv = `PLCC_LVL_2MA;
				endcase
			end
		endcase
		s.main_lvl = s.main_on ? lv : `PLCC_LVL_OFF;
		s.sub_lvl  = s.sub_on  ? lv : `PLCC_LVL_OFF;
		return s;
	endfunction

	// Synchronise asynchronous inputs. The pin, dropout and termination flags
	// come straight from outside, so each passes two flip-flops before any
	// logic reads it. A third flop holds the previous synchronised pin level
	// for edge detection; it resets low, matching the idle pin, so no false
	// edge follows reset.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_sync_reg  <= 2'h0;
			drop_sync_reg <= 2'h0;
			unt_sync_reg  <= 2'h0;
			pin_d_reg     <= 1'b0;
		end else if (clk_en) begin
			pin_sync_reg  <= {pin_sync_reg[0], ctrl_pin};
			drop_sync_reg <= {drop_sync_reg[0], sink_dropout};
			unt_sync_reg  <= {unt_sync_reg[0], sink_unterm};
			pin_d_reg     <= pin_sync_reg[1];
		end
	end

	assign pin_s = pin_sync_reg[1];
	assign rise  = pin_s & ~pin_d_reg;

	// Next state of the counter, timer and applied setting.
	// While off, only a rising edge matters: it turns the device on at the
	// first setting at once. While on, rises are counted, a long high run
	// latches the count into the sinks and a long low run turns the device off.
	// Between latches the count is private, so a fast burst never shows its
	// intermediate values at the outputs.
	always_comb begin
		st_next  = st_reg;
		cnt_next = cnt_reg;
		tmr_next = tmr_reg;
		idx_next = idx_reg;
		set_next = set_reg;
		// Timer: counts cycles at the present pin level and stops at the top,
		// so a held level cannot wrap it round into a second event.
		if (rise || (pin_s != pin_d_reg)) begin
			tmr_next = '0;    // Any level change restarts timing.
		end else if (tmr_reg != CW'(TMR_TOP)) begin
			tmr_next = tmr_reg + CW'(1);
		end
		case (st_reg)
			plcc_pkg::PLCC_ST_OFF: begin
				// A rise while off turns the device on at the first setting.
				if (rise) begin
					st_next  = plcc_pkg::PLCC_ST_ON;
					cnt_next = `PLCC_CNT_W'(1);
					idx_next = `PLCC_FIRST_SETTING;
					set_next = decode(`PLCC_FIRST_SETTING);
				end
			end
			plcc_pkg::PLCC_ST_ON: begin
				// Each rise adds one to the private count.
				if (rise) begin
					// Counts past sixteen hold at sixteen.
					if (cnt_reg != `PLCC_CNT_MAX) begin
						cnt_next = cnt_reg + `PLCC_CNT_W'(1);
					end
				end else if (pin_s && tmr_reg == CW'(LAT_CYCLES - 1) && cnt_reg != '0) begin
					// Only a latched count reaches the sinks.
					// The timer passes this value once per high run, so a latch fires once.
					idx_next = 4'(cnt_reg - `PLCC_CNT_W'(1));
					set_next = decode(4'(cnt_reg - `PLCC_CNT_W'(1)));
					cnt_next = '0;
				end else if (!pin_s && tmr_reg == CW'(OFF_CYCLES - 1)) begin
					// A long low run turns the device off and darkens the sinks.
					st_next  = plcc_pkg::PLCC_ST_OFF;
					cnt_next = '0;
					idx_next = '0;
					set_next = '0;
				end
			end
			default: begin
				// An illegal state code falls back to off.
				st_next = plcc_pkg::PLCC_ST_OFF;
			end
		endcase
	end

	// Register control state.
	// All state freezes while the clock enable is low; reset turns the device off.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg  <= plcc_pkg::PLCC_ST_OFF;
			cnt_reg <= '0;
			tmr_reg <= '0;
			idx_reg <= '0;
			set_reg <= '0;
		end else if (clk_en) begin
			st_reg  <= st_next;
			cnt_reg <= cnt_next;
			tmr_reg <= tmr_next;
			idx_reg <= idx_next;
			set_reg <= set_next;
		end
	end

	// Outputs come straight from the registers above.
	assign enabled     = (st_reg == plcc_pkg::PLCC_ST_ON);
	assign setting     = set_reg;
	assign setting_idx = idx_reg;

	// Pump mode sequencer.
	// It sees only synchronised flags and returns to 1X when the device turns off.
	plcc_pump_seq u_pump (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.enabled   (enabled),
		.dropout   (drop_sync_reg[1]),
		.unterm    (unt_sync_reg[1]),
		.pump_mode (pump_mode)
	);

endmodule // plcc_ctrl

// file: pkg/plcc_defs.svh
// Purpose: Timing counts and codes for the pulse-count LED current control.
// Assumes: 100 MHz system clock.
// Notes:   Times are in nanoseconds; cycle counts derive from them.
`ifndef PLCC_DEFS_SVH
`define PLCC_DEFS_SVH

`define PLCC_CLK_PERIOD_NS  10
`define PLCC_OFF_TIME_NS    500000
`define PLCC_LAT_TIME_NS    500000
`define PLCC_OFF_CYCLES     (`PLCC_OFF_TIME_NS / `PLCC_CLK_PERIOD_NS)
`define PLCC_LAT_CYCLES     (`PLCC_LAT_TIME_NS / `PLCC_CLK_PERIOD_NS)
`define PLCC_CNT_W          5
`define PLCC_CNT_MAX        5'h10
`define PLCC_FIRST_SETTING  4'h0

`define PLCC_LVL_OFF   3'h0
`define PLCC_LVL_20MA  3'h1
`define PLCC_LVL_14MA  3'h2
`define PLCC_LVL_10MA  3'h3
`define PLCC_LVL_7MA   3'h4
`define PLCC_LVL_50UA  3'h5
`define PLCC_LVL_500UA 3'h6
`define PLCC_LVL_1MA   3'h7
`define PLCC_LVL_2MA   3'h0

`endif

// file: pkg/plcc_pkg.sv
// Purpose: Types shared by the pulse-count LED current control.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Level codes come from the defs header.
package plcc_pkg;

	// Current level code for one sink group.
	typedef logic [2:0] plcc_level_t;

	// Setting applied to the sinks.
	typedef struct packed {
		logic        low_iq;   // Reduced quiescent low-current mode.
		logic        sub_on;   // Sub sink enabled.
		plcc_level_t sub_lvl;  // Sub sink level code.
		logic        main_on;  // Main sinks enabled.
		plcc_level_t main_lvl; // Main sinks level code.
	} plcc_setting_t;

	// Backlight pump modes.
	typedef enum logic [2:0] {
		PLCC_PUMP_1X  = 3'h1,
		PLCC_PUMP_15X = 3'h2,
		PLCC_PUMP_2X  = 3'h4
	} plcc_pump_t;

	// Control states of the link.
	typedef enum logic [1:0] {
		PLCC_ST_OFF = 2'h1,
		PLCC_ST_ON  = 2'h2
	} plcc_state_t;

endpackage

// file: rtl/plcc_pump_seq.sv
// Purpose: Backlight pump mode sequencing from sink dropout.
// Assumes: Dropout and termination flags are synchronous to clk.
// Notes:   Mode returns to 1X only when the device turns off.
`include "plcc_defs.svh"

module plcc_pump_seq (
	input  wire logic                clk,         // System clock.
	input  wire logic                sys_rst,     // Asynchronous reset, active high.
	input  wire logic                clk_en,      // Freezes state while low.
	input  wire logic                enabled,     // Device is on.
	input  wire logic                dropout,     // Any sink near dropout.
	input  wire logic                unterm,      // An unused sink is not tied off.
	output plcc_pkg::plcc_pump_t     pump_mode    // Current pump mode.
);

	plcc_pkg::plcc_pump_t mode_reg;   // Registered mode.
	plcc_pkg::plcc_pump_t mode_next;  // Next mode.

	// Next mode: step up on dropout, never step down while on.
	always_comb begin
		mode_next = mode_reg;
		if (!enabled) begin
			mode_next = plcc_pkg::PLCC_PUMP_1X;    // Off returns to load switch.
		end else if (unterm) begin
			mode_next = plcc_pkg::PLCC_PUMP_2X;
		end else if (dropout) begin
			case (mode_reg)
				plcc_pkg::PLCC_PUMP_1X:  mode_next = plcc_pkg::PLCC_PUMP_15X;
				plcc_pkg::PLCC_PUMP_15X: mode_next = plcc_pkg::PLCC_PUMP_2X;
				default:                 mode_next = plcc_pkg::PLCC_PUMP_2X;  // Stay at top.
			endcase
		end
	end

	// Register the mode.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_reg <= plcc_pkg::PLCC_PUMP_1X;
		end else if (clk_en) begin
			mode_reg <= mode_next;
		end
	end

	assign pump_mode = mode_reg;

endmodule // plcc_pump_seq

// file: bench/plcc_ctrl_monitor.sv
// Purpose: Port checks for the pulse-count current control.
// Assumes: clk_en held high by the bench.
// Notes:   Run-length counters follow the raw pin level.
`include "plcc_defs.svh"
module plcc_ctrl_monitor #(
	parameter int unsigned OFF_CYCLES = 60, // Off timeout in clocks.
	parameter int unsigned LAT_CYCLES = 40  // Latch timeout in clocks.
) (
	input wire logic                    clk,         // System clock.
	input wire logic                    sys_rst,     // Reset, active high.
	input wire logic                    ctrl_pin,    // Control pin.
	input wire logic                    sink_unterm, // Unterminated sink flag.
	input wire logic                    enabled,     // Device on.
	input wire plcc_pkg::plcc_setting_t setting,     // Applied setting.
	input wire logic [3:0]              setting_idx, // Applied index.
	input wire plcc_pkg::plcc_pump_t    pump_mode    // Pump mode.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] hi_reg, hi_next, lo_reg, lo_next; // Pin high and low run lengths.
	// Counts cycles at the present pin level, saturating.
	always_comb begin
		hi_next = ctrl_pin ? hi_reg + {15'h0, ~&hi_reg} : 16'h0;
		lo_next = ctrl_pin ? 16'h0 : lo_reg + {15'h0, ~&lo_reg};
	end
	// Registers the run lengths.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hi_reg <= 16'h0;
			lo_reg <= 16'h0;
		end else begin
			hi_reg <= hi_next;
			lo_reg <= lo_next;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_no_unterm;
		(!sink_unterm && enabled)[*6];
	endsequence
	sequence s_left_1x;
		$past(pump_mode) == plcc_pkg::PLCC_PUMP_1X && pump_mode != plcc_pkg::PLCC_PUMP_1X;
	endsequence
	a_first_on: assert property ($rose(enabled) |-> setting_idx == 4'h0 &&
		setting == {1'b0, 1'b1, `PLCC_LVL_20MA, 1'b1, `PLCC_LVL_20MA} &&
		$past(ctrl_pin, 3)) else $error("enable setting wrong");
	a_group_map: assert property (enabled |->
		setting.main_on == (setting_idx < 4'h8 || setting_idx > 4'hb) &&
		setting.sub_on == (setting_idx < 4'h4 || setting_idx > 4'h7) &&
		setting.low_iq == (setting_idx > 4'hb)) else $error("group map wrong");
	a_latch_wait: assert property (enabled && $past(enabled) && $changed(setting) |->
		hi_reg >= LAT_CYCLES) else $error("setting changed early");
	a_off_early: assert property ($fell(enabled) |-> lo_reg >= OFF_CYCLES)
		else $error("device off early");
	a_off_late: assert property (lo_reg == OFF_CYCLES + 8 |-> !enabled)
		else $error("device still on");
	a_off_clear: assert property ($fell(enabled) |-> setting == '0 && setting_idx == 4'h0)
		else $error("setting not cleared");
	a_pump_start: assert property (s_no_unterm ##0 s_left_1x |->
		pump_mode == plcc_pkg::PLCC_PUMP_15X) else $error("pump skipped 1.5X");
	a_pump_next: assert property ($past(pump_mode) == plcc_pkg::PLCC_PUMP_15X && enabled &&
		pump_mode != plcc_pkg::PLCC_PUMP_15X |-> pump_mode == plcc_pkg::PLCC_PUMP_2X)
		else $error("pump left 1.5X wrongly");
	a_unterm_2x: assert property ((sink_unterm && enabled)[*6] |->
		pump_mode == plcc_pkg::PLCC_PUMP_2X) else $error("pump not 2X");
endmodule // plcc_ctrl_monitor

bind plcc_ctrl plcc_ctrl_monitor #(.OFF_CYCLES(OFF_CYCLES), .LAT_CYCLES(LAT_CYCLES)) u_mon (
	.clk(clk), .sys_rst(sys_rst), .ctrl_pin(ctrl_pin), .sink_unterm(sink_unterm),
	.enabled(enabled), .setting(setting), .setting_idx(setting_idx), .pump_mode(pump_mode));

// file: bench/plcc_host_model.sv
// Purpose: Host that drives the control pin with counted pulses.
// Assumes: Pin changes on falling clock edges.
// Notes:   Each phase lasts five clocks.
module plcc_host_model (
	input  wire logic clk,     // System clock.
	output logic      ctrl_pin // Control pin to the device.
);
	timeunit 1ns;
	timeprecision 1ps;
	initial ctrl_pin = 1'b0;
	// Sends n pulses and leaves the pin high so the setting holds.
	task automatic burst(input int n);
		repeat (n) begin
			ctrl_pin = 1'b0;
			repeat (5) @(negedge clk);
			ctrl_pin = 1'b1;
			repeat (5) @(negedge clk);
		end
	endtask
	// Lowers the pin so the device turns off.
	task automatic drop();
		ctrl_pin = 1'b0;
	endtask
endmodule // plcc_host_model

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the pulse-count current control.
// Assumes: Timeouts shortened to 40 and 60 clocks.
// Notes:   Scenarios run in order after reset.
`include "plcc_defs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned LAT = 40; // Latch timeout used here.
	localparam int unsigned OFF = 60; // Off timeout used here.
	logic                    clk = 1'b0;     // Clock.
	logic                    sys_rst = 1'b1; // Reset.
	logic                    drop = 1'b0;    // Dropout flag.
	logic                    unterm = 1'b0;  // Unterminated flag.
	logic                    pin;            // Control pin.
	logic                    en;             // Device on.
	logic [3:0]              idx;            // Applied index.
	plcc_pkg::plcc_setting_t set;            // Applied setting.
	plcc_pkg::plcc_pump_t    pump;           // Pump mode.
	int                      n_errors = 0;   // Mismatches.
	int                      n_compared = 0; // Comparisons.
	always #5 clk = ~clk;
	plcc_host_model u_host (.clk(clk), .ctrl_pin(pin));
	plcc_ctrl #(.OFF_CYCLES(OFF), .LAT_CYCLES(LAT)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.clk_en(1'b1), .ctrl_pin(pin), .sink_dropout(drop), .sink_unterm(unterm),
		.enabled(en), .setting(set), .setting_idx(idx), .pump_mode(pump));
	// Expected setting for a pulse count, built from the level codes.
	function automatic plcc_pkg::plcc_setting_t exp_set(input int n);
		logic [2:0] l;
		case ((n - 1) % 4)
			0:       l = (n > 12) ? `PLCC_LVL_50UA : `PLCC_LVL_20MA;
			1:       l = (n > 12) ? `PLCC_LVL_500UA : `PLCC_LVL_14MA;
			2:       l = (n > 12) ? `PLCC_LVL_1MA : `PLCC_LVL_10MA;
			default: l = (n > 12) ? `PLCC_LVL_2MA : `PLCC_LVL_7MA;
		endcase
		exp_set = '0;
		exp_set.low_iq = (n > 12);
		exp_set.main_on = (n < 9) || (n > 12);
		exp_set.sub_on = (n < 5) || (n > 8);
		exp_set.main_lvl = exp_set.main_on ? l : `PLCC_LVL_OFF;
		exp_set.sub_lvl = exp_set.sub_on ? l : `PLCC_LVL_OFF;
	endfunction
	task automatic chk_set(input plcc_pkg::plcc_setting_t g, input plcc_pkg::plcc_setting_t e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_val(input logic [3:0] g, input logic [3:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic summarize();
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Drops the pin, waits a bounded time for turn-off, checks cleared outputs.
	task automatic go_off();
		int i;
		u_host.drop();
		for (i = 0; i < OFF + 16 && en !== 1'b0; i++) @(negedge clk);
		if (en !== 1'b0) begin
			n_errors++;
			summarize();
		end
		chk_set(set, '0);
		chk_val(idx, 4'h0);
	endtask
	// Enables with one pulse, adds the rest, holds for the latch.
	task automatic t_count(input int n, input int e);
		u_host.burst(1);
		chk_val({3'h0, en}, 4'h1);
		chk_set(set, exp_set(1));
		u_host.burst(n - 1);
		repeat (LAT + 8) @(negedge clk);
		chk_set(set, exp_set(e));
		chk_val(idx, 4'(e - 1));
		go_off();
	endtask
	// Relatches a new burst, then walks the pump modes.
	task automatic t_pump();
		u_host.burst(2);
		repeat (LAT + 8) @(negedge clk);
		u_host.burst(5);
		repeat (LAT + 8) @(negedge clk);
		chk_set(set, exp_set(5));
		chk_val({1'b0, pump}, {1'b0, plcc_pkg::PLCC_PUMP_1X});
		for (int i = 0; i < 2; i++) begin
			drop = 1'b1;
			@(negedge clk);
			drop = 1'b0;
			repeat (6) @(negedge clk);
			if (i == 0) chk_val({1'b0, pump}, {1'b0, plcc_pkg::PLCC_PUMP_15X});
			else chk_val({1'b0, pump}, {1'b0, plcc_pkg::PLCC_PUMP_2X});
		end
		chk_val({1'b0, pump}, 4'h4);
		go_off();
		u_host.burst(1);
		unterm = 1'b1;
		repeat (8) @(negedge clk);
		chk_val({1'b0, pump}, 4'h4);
		unterm = 1'b0;
		go_off();
	endtask
	initial begin
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		for (int n = 1; n <= 16; n++) t_count(n, n);
		t_count(20, 16);
		t_pump();
		summarize();
	end
endmodule // tb_top
